// ---- hdl/opmem.sv ----
// operand memory with area decode, bit access, indirect retentive access and terminal transfer
// assumes the execution unit holds its request stable for the access cycle and pulses SCAN_END once per pass
//
// Function
// - words are sixteen bits, bit 00 rightmost
// - retentive, timer and link need selector
// - word address two digits, bit four digits
// - bit field above 15 is invalid
// - timer word gives value, bit gives done
// - four digits per word, 0 rightmost
// - decimal stored BCD, hex stored binary
// - BCD digit above nine is invalid
// - integers only; timer rightmost digit tenths
// - direct operand read from addressed word
// - indirect retentive word names the real word
// - word 00 inputs, word 01 outputs, in order
// - after pass: outputs out and inputs latched on the same edge
// - work bit ranges depend on variant
// - small variant bits 0006, 0007 unusable
// - error flag on bad BCD operand
// - retentive area survives power interruptions
`timescale 1ns/1ps
module opmem #(
	parameter logic [1:0] VARIANT = opmem_pkg::VARIANT_SMALL,
	parameter int IN_COUNT = 6,
	parameter int OUT_COUNT = 4
) (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic ACC_VALID,
	input wire logic ACC_WRITE,
	input wire logic ACC_BIT,
	input wire logic [1:0] ACC_AREA,
	input wire logic ACC_INDIRECT,
	input wire logic ACC_CHECK_BCD,
	input wire logic [7:0] ACC_WORD,
	input wire logic [7:0] ACC_BITNUM,
	input wire logic [15:0] ACC_WDATA,
	output logic [15:0] ACC_RDATA,
	output logic ACC_INVALID,
	output logic ACC_BCD_BAD,
	input wire logic [15:0] TC_VALUE [opmem_pkg::TC_COUNT],
	input wire logic [15:0] TC_DONE,
	input wire logic SCAN_END,
	input wire logic [IN_COUNT-1:0] IN_TERM,
	output logic [OUT_COUNT-1:0] OUT_TERM,
	output logic ERROR_FLAG
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [15:0] plain_q [opmem_pkg::PLAIN_WORDS];
	logic [15:0] ret_q [opmem_pkg::RETENTIVE_WORDS];
	logic [15:0] link_q [opmem_pkg::LINK_WORDS];
	logic [IN_COUNT-1:0] in_meta_q, in_sync_q;
	logic [OUT_COUNT-1:0] out_q;
	logic err_q;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	opmem_pkg::area_t area;
	logic [3:0] bit_sel;
	logic [4:0] plain_idx;
	logic [3:0] ret_idx;
	logic [3:0] eff_ret;
	logic [15:0] indirect_word;
	logic bit_field_bad, word_ok, bcd_bad, ind_bad;
	logic [15:0] word_val, usable, new_word;
	logic [3:0] tens, ones;

	assign area = opmem_pkg::area_t'(ACC_AREA);
	assign tens = ACC_WORD[7:4];
	assign ones = ACC_WORD[3:0];
	// bit number is two BCD digits 00..15
	assign bit_field_bad = ACC_BIT && (ACC_BITNUM[7:4] > 4'h1 || ACC_BITNUM[3:0] > 4'h9 ||
		(ACC_BITNUM[7:4] == 4'h1 && ACC_BITNUM[3:0] > 4'h5));
	assign bit_sel = ACC_BITNUM[7:4] == 4'h1 ? 4'(ACC_BITNUM[3:0] + 4'hA) : ACC_BITNUM[3:0];
	// word number from two BCD digits, 00..20 maps to 0..20
	assign plain_idx = 5'(tens * 4'hA + ones);
	assign ret_idx = 4'(tens * 4'hA + ones);
	assign indirect_word = ret_q[ret_idx];
	// indirect content is a BCD word number
	assign eff_ret = 4'(indirect_word[7:4] * 4'hA + indirect_word[3:0]);
	assign ind_bad = ACC_INDIRECT && (indirect_word[15:8] != 8'h00 ||
		indirect_word[7:4] > 4'h1 || (indirect_word[7:4] == 4'h1 && indirect_word[3:0] > 4'h5));

	function automatic logic [15:0] plain_mask(input logic [4:0] idx);
		logic [15:0] m;
		m = 16'h0000;
		case (idx)
			5'h00: m = (VARIANT == opmem_pkg::VARIANT_SMALL) ? opmem_pkg::MASK_IN_SMALL : opmem_pkg::MASK_ALL;
			5'h01, 5'h02: m = opmem_pkg::MASK_ALL;
			default: begin
				// words 10..20 only in larger variants
				if (idx >= 5'h0A && idx <= 5'h14 && VARIANT != opmem_pkg::VARIANT_SMALL)
					m = opmem_pkg::MASK_ALL;
				else if (idx == 5'h03)
					m = opmem_pkg::MASK_ALL;
			end
		endcase
		return m;
	endfunction

	always_comb begin
		word_ok = 1'b0;
		word_val = 16'h0000;
		usable = 16'h0000;
		case (area)
			opmem_pkg::AREA_PLAIN: begin
				word_ok = ones <= 4'h9 && tens <= 4'h2 && plain_idx < 5'(opmem_pkg::PLAIN_WORDS);
				usable = plain_mask(plain_idx);
				word_ok = word_ok && usable != 16'h0000;
				word_val = plain_q[plain_idx] & usable;
			end
			opmem_pkg::AREA_RETENTIVE: begin
				word_ok = ones <= 4'h9 && tens <= 4'h1 && plain_idx < 5'(opmem_pkg::RETENTIVE_WORDS) && !ind_bad;
				usable = opmem_pkg::MASK_ALL;
				word_val = ACC_INDIRECT ? ret_q[eff_ret] : ret_q[ret_idx];
			end
			opmem_pkg::AREA_LINK: begin
				word_ok = tens == 4'h0 && ones < 4'(opmem_pkg::LINK_WORDS);
				usable = opmem_pkg::MASK_ALL;
				word_val = link_q[ones[2:0]];
			end
			opmem_pkg::AREA_TIMER_COUNTER: begin
				word_ok = ones <= 4'h9 && tens <= 4'h1 && plain_idx < 5'(opmem_pkg::TC_COUNT);
				// timer values are read only; rightmost digit is tenths
				word_val = ACC_BIT ? {15'h0000, TC_DONE[ret_idx]} : TC_VALUE[ret_idx];
			end
			default: begin
				word_ok = 1'b0;
			end
		endcase
	end

	assign ACC_INVALID = ACC_VALID && (!word_ok || (bit_field_bad && area != opmem_pkg::AREA_TIMER_COUNTER));
	bcd_check #(.DIGITS(4)) u_bcd (.word_in(word_val), .bad(bcd_bad));
	// single-cycle combinational answer
	always_comb begin
		if (!ACC_VALID || ACC_INVALID)
			ACC_RDATA = 16'h0000;
		else if (ACC_BIT && area != opmem_pkg::AREA_TIMER_COUNTER)
			ACC_RDATA = {15'h0000, word_val[bit_sel]};
		else
			ACC_RDATA = word_val;
	end
	assign ACC_BCD_BAD = ACC_VALID && !ACC_INVALID && !ACC_BIT &&
		bcd_bad && (ACC_CHECK_BCD || ACC_INDIRECT);

	// merged word for writes; unusable bits keep zero
	always_comb begin
		if (ACC_BIT) begin
			new_word = word_val;
			new_word[bit_sel] = ACC_WDATA[0];
		end else begin
			new_word = ACC_WDATA;
		end
		new_word = new_word & usable;
	end

	logic do_write;
	assign do_write = ACC_VALID && ACC_WRITE && !ACC_INVALID && area != opmem_pkg::AREA_TIMER_COUNTER;

	// ------------------------------------------------------------
	// input terminal synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			in_meta_q <= '0;
			in_sync_q <= '0;
		end else begin
			in_meta_q <= IN_TERM;
			in_sync_q <= in_meta_q;
		end
	end

	// ------------------------------------------------------------
	// plain area, with end-of-pass terminal transfer
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < opmem_pkg::PLAIN_WORDS; i++)
				plain_q[i] <= opmem_pkg::RESET_WORD;
		end else begin
			if (do_write && area == opmem_pkg::AREA_PLAIN)
				plain_q[plain_idx] <= new_word;
			if (SCAN_END)
				plain_q[0][IN_COUNT-1:0] <= in_sync_q;
			plain_q[3][opmem_pkg::ERROR_FLAG_BIT] <= err_q;
		end
	end

	// ------------------------------------------------------------
	// retentive and link areas
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < opmem_pkg::LINK_WORDS; i++)
				link_q[i] <= opmem_pkg::RESET_WORD;
		end else if (do_write && area == opmem_pkg::AREA_LINK) begin
			link_q[ones[2:0]] <= new_word;
		end
	end

	// no reset: contents kept across resets
	always_ff @(posedge CLOCK) begin
		if (do_write && area == opmem_pkg::AREA_RETENTIVE)
			ret_q[ACC_INDIRECT ? eff_ret : ret_idx] <= new_word;
	end

	// ------------------------------------------------------------
	// output terminals and error flag
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N)
			out_q <= '0;
		else if (SCAN_END)
			out_q <= plain_q[1][OUT_COUNT-1:0];
	end
	assign OUT_TERM = out_q;

	// set wins over end-of-pass clear
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N)
			err_q <= 1'b0;
		else if (ACC_BCD_BAD)
			err_q <= 1'b1;
		else if (SCAN_END)
			err_q <= 1'b0;
	end
	assign ERROR_FLAG = err_q;
endmodule // opmem

// ---- hdl/opmem_pkg.sv ----
// package for the operand memory and address decoder
// assumes one controller clock and an active-low asynchronous reset
package opmem_pkg;
	// ------------------------------------------------------------
	// area selector codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		AREA_PLAIN,
		AREA_RETENTIVE,
		AREA_TIMER_COUNTER,
		AREA_LINK
	} area_t;

	// ------------------------------------------------------------
	// variants of the controller
	// ------------------------------------------------------------
	localparam logic [1:0] VARIANT_SMALL = 2'h0;
	localparam logic [1:0] VARIANT_MID = 2'h1;
	localparam logic [1:0] VARIANT_LARGE = 2'h2;

	// ------------------------------------------------------------
	// word layout and area sizes
	// ------------------------------------------------------------
	localparam int WORD_BITS = 16;
	localparam int DIGIT_BITS = 4;
	localparam int PLAIN_WORDS = 21;
	localparam int RETENTIVE_WORDS = 16;
	localparam int LINK_WORDS = 8;
	localparam int TC_COUNT = 16;
	localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
	localparam logic [3:0] BIT_MAX = 4'hF;

	// ------------------------------------------------------------
	// word numbers in the plain area
	// ------------------------------------------------------------
	localparam logic [7:0] WORD_INPUT = 8'h00;
	localparam logic [7:0] WORD_OUTPUT = 8'h01;
	localparam logic [7:0] WORD_WORK = 8'h02;
	localparam logic [7:0] WORD_FLAGS = 8'h03;
	localparam logic [7:0] WORD_EXT_FIRST = 8'h10;
	localparam logic [7:0] WORD_EXT_LAST = 8'h20;
	localparam int ERROR_FLAG_BIT = 11;

	// ------------------------------------------------------------
	// usable bit masks per variant for words 00 and 01
	// ------------------------------------------------------------
	localparam logic [15:0] MASK_IN_SMALL = 16'hFF3F;
	localparam logic [15:0] MASK_OUT_SMALL = 16'hFFFF;
	localparam logic [15:0] MASK_ALL = 16'hFFFF;
	localparam logic [15:0] RESET_WORD = 16'h0000;
endpackage

// ---- hdl/bcd_check.sv ----
// checks a word for BCD digits above nine
// assumes nothing beyond a 16-bit word
`timescale 1ns/1ps
module bcd_check #(
	parameter int DIGITS = 4
) (
	input wire logic [DIGITS*4-1:0] word_in,
	output logic bad
);
	logic [DIGITS-1:0] digit_bad;

	genvar g;
	generate
		for (g = 0; g < DIGITS; g++) begin : g_digit
			// digit g occupies bits 4g+3..4g
			assign digit_bad[g] = word_in[g*4 +: 4] > opmem_pkg::BCD_MAX_DIGIT;
		end
	endgenerate

	assign bad = |digit_bad;
endmodule // bcd_check

// ---- dv/opmem_properties.sv ----
// port assertions for the operand memory
// assumes the small variant; bound to every opmem instance below
`timescale 1ns/1ps
module opmem_properties #(
	parameter int IN_COUNT = 6,
	parameter int OUT_COUNT = 4
) (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic ACC_VALID,
	input wire logic ACC_WRITE,
	input wire logic ACC_BIT,
	input wire logic [1:0] ACC_AREA,
	input wire logic ACC_INDIRECT,
	input wire logic ACC_CHECK_BCD,
	input wire logic [7:0] ACC_WORD,
	input wire logic [7:0] ACC_BITNUM,
	input wire logic [15:0] ACC_WDATA,
	input wire logic [15:0] ACC_RDATA,
	input wire logic ACC_INVALID,
	input wire logic ACC_BCD_BAD,
	input wire logic [15:0] TC_VALUE [opmem_pkg::TC_COUNT],
	input wire logic [15:0] TC_DONE,
	input wire logic SCAN_END,
	input wire logic [OUT_COUNT-1:0] OUT_TERM,
	input wire logic ERROR_FLAG
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	wire logic rd = ACC_VALID && !ACC_WRITE;
	wire logic tc = rd && ACC_AREA == 2'h2 && ACC_WORD < 8'h0A;
	a_idle_zero: assert property (!ACC_VALID || ACC_INVALID |-> ACC_RDATA == 16'h0000) else $error("rdata not zero");
	a_bit_range: assert property (ACC_VALID && ACC_BIT && ACC_AREA != 2'h2 && ACC_BITNUM > 8'h15 |-> ACC_INVALID)
		else $error("bit field accepted");
	a_write_back: assert property (ACC_VALID && ACC_WRITE && !ACC_BIT && ACC_AREA == 2'h0 && ACC_WORD == 8'h02
		##1 rd && !ACC_BIT && ACC_AREA == 2'h0 && ACC_WORD == 8'h02 |-> ACC_RDATA == $past(ACC_WDATA))
		else $error("write lost");
	a_tc_value: assert property (tc && !ACC_BIT |-> ACC_RDATA == TC_VALUE[ACC_WORD[3:0]]) else $error("tc value");
	a_tc_done: assert property (tc && ACC_BIT |-> ACC_RDATA == {15'h0000, TC_DONE[ACC_WORD[3:0]]}) else $error("tc done");
	a_out_hold: assert property (!$past(SCAN_END) |-> $stable(OUT_TERM)) else $error("outputs moved");
	a_err_set: assert property (ACC_BCD_BAD |=> ERROR_FLAG) else $error("error not set");
	a_err_clear: assert property (SCAN_END && !ACC_BCD_BAD |=> !ERROR_FLAG) else $error("error not cleared");
	a_bcd_bad: assert property (rd && !ACC_BIT && ACC_CHECK_BCD && !ACC_INDIRECT && !ACC_INVALID
		&& ACC_RDATA[3:0] > 4'h9 |-> ACC_BCD_BAD) else $error("bcd digit passed");
	c_bcd: cover property (ACC_BCD_BAD);
	c_scan: cover property (SCAN_END ##1 OUT_TERM != '0);
	c_indirect: cover property (rd && ACC_INDIRECT);
endmodule // opmem_properties
bind opmem opmem_properties #(.IN_COUNT(IN_COUNT), .OUT_COUNT(OUT_COUNT)) u_props (.CLOCK(CLOCK), .RESET_N(RESET_N),
	.ACC_VALID(ACC_VALID), .ACC_WRITE(ACC_WRITE), .ACC_BIT(ACC_BIT), .ACC_AREA(ACC_AREA), .ACC_INDIRECT(ACC_INDIRECT),
	.ACC_CHECK_BCD(ACC_CHECK_BCD), .ACC_WORD(ACC_WORD), .ACC_BITNUM(ACC_BITNUM), .ACC_WDATA(ACC_WDATA),
	.ACC_RDATA(ACC_RDATA), .ACC_INVALID(ACC_INVALID), .ACC_BCD_BAD(ACC_BCD_BAD), .TC_VALUE(TC_VALUE),
	.TC_DONE(TC_DONE), .SCAN_END(SCAN_END), .OUT_TERM(OUT_TERM), .ERROR_FLAG(ERROR_FLAG));

// ---- dv/exec_model.sv ----
// model of the instruction execution unit issuing operand accesses
// assumes the bench calls its tasks; all changes at the falling edge
`timescale 1ns/1ps
module exec_model (
	input wire logic clock,
	output logic valid,
	output logic write,
	output logic bit_acc,
	output logic [1:0] area,
	output logic indirect,
	output logic check_bcd,
	output logic [7:0] word,
	output logic [7:0] bitnum,
	output logic [15:0] wdata,
	output logic scan_end
);
	initial {valid, write, bit_acc, area, indirect, check_bcd, word, bitnum, wdata, scan_end} = '0;
	task automatic acc(input logic w, b, input logic [1:0] a, input logic i, c, input logic [7:0] wd, bn,
		input logic [15:0] d);
		@(negedge clock);
		{valid, write, bit_acc, area, indirect, check_bcd} = {1'b1, w, b, a, i, c};
		word = wd;
		bitnum = bn;
		wdata = d;
	endtask
	// released data lines show the inverse, not the last value
	task automatic pass_end();
		@(negedge clock);
		valid = 1'b0;
		wdata = ~wdata;
		word = ~word;
		bitnum = ~bitnum;
		scan_end = 1'b1;
		@(negedge clock);
		scan_end = 1'b0;
	endtask
endmodule // exec_model

// ---- dv/plc_data_area_addressing_tb_top.sv ----
// self-checking bench for the operand memory, small variant
// assumes exec_model drives the access side
`timescale 1ns/1ps
module plc_data_area_addressing_tb_top;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic valid, write, bit_acc, indirect, check_bcd, scan_end, invalid, bcd_bad, error_flag;
	logic [1:0] area;
	logic [7:0] word, bitnum;
	logic [15:0] wdata, rdata, tc_done, d, o, seed = 16'h005E;
	logic [15:0] tc_value [opmem_pkg::TC_COUNT];
	logic [5:0] in_term = 6'h00;
	logic [3:0] out_term;
	logic [16:0] exp_q [$];
	int err_count = 0;
	int check_count = 0;
	always #5 clock = ~clock;
	exec_model u_ex (.clock(clock), .valid(valid), .write(write), .bit_acc(bit_acc), .area(area), .indirect(indirect),
		.check_bcd(check_bcd), .word(word), .bitnum(bitnum), .wdata(wdata), .scan_end(scan_end));
	opmem #(.VARIANT(opmem_pkg::VARIANT_SMALL), .IN_COUNT(6), .OUT_COUNT(4)) u_dut (.CLOCK(clock), .RESET_N(reset_n),
		.ACC_VALID(valid), .ACC_WRITE(write), .ACC_BIT(bit_acc), .ACC_AREA(area), .ACC_INDIRECT(indirect),
		.ACC_CHECK_BCD(check_bcd), .ACC_WORD(word), .ACC_BITNUM(bitnum), .ACC_WDATA(wdata), .ACC_RDATA(rdata),
		.ACC_INVALID(invalid), .ACC_BCD_BAD(bcd_bad), .TC_VALUE(tc_value), .TC_DONE(tc_done), .SCAN_END(scan_end),
		.IN_TERM(in_term), .OUT_TERM(out_term), .ERROR_FLAG(error_flag));
	function automatic logic [15:0] xs();
		seed ^= seed << 7;
		seed ^= seed >> 9;
		seed ^= seed << 8;
		return seed;
	endfunction
	task automatic cmp(input string what, input logic [16:0] e, input logic [16:0] s);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic cmp_pins(input string what, input logic [16:0] e, input logic [16:0] s);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic rd(input logic b, input logic [1:0] a, input logic i, c, input logic [7:0] w, n, input logic [16:0] e);
		u_ex.acc(1'b0, b, a, i, c, w, n, 16'h0000);
		exp_q.push_back(e);
	endtask
	task automatic wr(input logic b, input logic [1:0] a, input logic [7:0] w, n, input logic [15:0] v);
		u_ex.acc(1'b1, b, a, 1'b0, 1'b0, w, n, v);
	endtask
	task automatic end_sim();
		err_count += exp_q.size();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// read results are judged when they appear
	always @(posedge clock) begin
		if (reset_n && valid && !write) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("BAD read expected none seen %h", {invalid, rdata});
			end else begin
				cmp("read", exp_q.pop_front(), {invalid, rdata});
			end
		end
	end
	initial begin
		#100000;
		err_count++;
		end_sim();
	end
	initial begin
		tc_done = xs();
		foreach (tc_value[k]) tc_value[k] = xs();
		repeat (5) @(negedge clock);
		reset_n = 1'b1;
		cmp_pins("reset", 17'h00000, {error_flag, 12'h000, out_term});
		d = xs();
		o = xs();
		in_term = o[13:8];
		wr(1'b0, 2'h0, 8'h02, 8'h00, d);
		rd(1'b0, 2'h0, 1'b0, 1'b0, 8'h02, 8'h00, {1'b0, d});
		for (int k = 0; k < 16; k++) begin
			rd(1'b1, 2'h0, 1'b0, 1'b0, 8'h02, 8'((k / 10) * 16 + k % 10), {16'h0000, d[k]});
		end
		rd(1'b1, 2'h0, 1'b0, 1'b0, 8'h02, 8'h16, 17'h10000);
		wr(1'b0, 2'h2, 8'h03, 8'h00, ~tc_value[3]);
		rd(1'b0, 2'h2, 1'b0, 1'b0, 8'h03, 8'h00, {1'b0, tc_value[3]});
		rd(1'b1, 2'h2, 1'b0, 1'b0, 8'h03, 8'h00, {16'h0000, tc_done[3]});
		wr(1'b0, 2'h1, 8'h02, 8'h00, 16'h0006);
		wr(1'b0, 2'h1, 8'h06, 8'h00, 16'h1234);
		rd(1'b0, 2'h1, 1'b1, 1'b0, 8'h02, 8'h00, 17'h01234);
		rd(1'b0, 2'h0, 1'b0, 1'b0, 8'h02, 8'h00, {1'b0, d});
		wr(1'b1, 2'h0, 8'h00, 8'h06, 16'h0001);
		rd(1'b1, 2'h0, 1'b0, 1'b0, 8'h00, 8'h06, 17'h00000);
		rd(1'b0, 2'h0, 1'b0, 1'b0, 8'h10, 8'h00, 17'h10000);
		wr(1'b0, 2'h3, 8'h07, 8'h00, o);
		rd(1'b0, 2'h3, 1'b0, 1'b0, 8'h07, 8'h00, {1'b0, o});
		rd(1'b1, 2'h3, 1'b0, 1'b0, 8'h07, 8'h15, {16'h0000, o[15]});
		rd(1'b0, 2'h3, 1'b0, 1'b0, 8'h08, 8'h00, 17'h10000);
		wr(1'b0, 2'h1, 8'h03, 8'h00, 16'h0016);
		rd(1'b0, 2'h1, 1'b1, 1'b0, 8'h03, 8'h00, 17'h10000);
		wr(1'b0, 2'h0, 8'h01, 8'h00, o);
		wr(1'b0, 2'h0, 8'h02, 8'h00, 16'h00B0);
		rd(1'b0, 2'h0, 1'b0, 1'b1, 8'h02, 8'h00, 17'h000B0);
		wr(1'b0, 2'h0, 8'h02, 8'h00, d);
		cmp_pins("error", 17'h00001, {16'h0000, error_flag});
		u_ex.pass_end();
		cmp_pins("scan", {13'h0000, o[3:0]}, {error_flag, 12'h000, out_term});
		for (int k = 0; k < 6; k++) begin
			rd(1'b1, 2'h0, 1'b0, 1'b0, 8'h00, 8'(k), {16'h0000, o[8 + k]});
		end
		u_ex.pass_end();
		// mid-run reset: outputs clear, retentive words stay
		reset_n = 1'b0;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		cmp_pins("reset", 17'h00000, {error_flag, 12'h000, out_term});
		rd(1'b0, 2'h1, 1'b0, 1'b0, 8'h06, 8'h00, 17'h01234);
		rd(1'b0, 2'h0, 1'b0, 1'b0, 8'h02, 8'h00, 17'h00000);
		u_ex.pass_end();
		end_sim();
	end
endmodule // plc_data_area_addressing_tb_top
